// file: common/cssr_consts.vh
// Constants for the clock speed select and warm reset block
`ifndef CSSR_CONSTS_VH
`define CSSR_CONSTS_VH

// Register offsets
`define CSSR_CTRL_OFF 8'h8F
`define CSSR_STAT_OFF 8'hFE

// Control register reset value and writable bits
`define CSSR_CTRL_RESET 8'h00
`define CSSR_CTRL_WMASK 8'h7F

// Control register fields
`define CSSR_BIT_CPU 0
`define CSSR_BIT_TIMER0 1
`define CSSR_BIT_TIMER1 2
`define CSSR_BIT_TIMER2 3
`define CSSR_BIT_SERIAL 4
`define CSSR_BIT_CNTARR 5
`define CSSR_BIT_WDOG 6
`define CSSR_BIT_RSVD 7
`define CSSR_NUM_PERIPH 6

// Status register fields
`define CSSR_STAT_X2 0
`define CSSR_STAT_PIN 1
`define CSSR_STAT_WDOG 2
`define CSSR_STAT_INT 3
`define CSSR_STAT_ACTIVE 4
`define CSSR_STAT_CLRMASK 8'h0E

// Oscillator periods per cycle
`define CSSR_STD_PERIODS 12
`define CSSR_X2_PERIODS 6

// Warm reset timing in oscillator periods
`define CSSR_WARM_MIN_PERIODS 24
`define CSSR_PULSE_PERIODS 24

`endif

// file: hw/cssr_rate_gen.v
// Oscillator period counter, divide-by-two stage and speed bit validation
`timescale 1ns/1ns
`include "cssr_consts.vh"

module cssr_rate_gen (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Requested double speed from the control register
  input wire x2_req,
  // Timing outputs
  output reg div2_q,
  output reg x2_eff_q,
  output wire en6,
  output wire en12
);

  // Period counts cut to the counter width on purpose, both fit in four bits
  localparam integer STD_INT = `CSSR_STD_PERIODS - 1;
  localparam integer X2_INT = `CSSR_X2_PERIODS - 1;
  localparam [3:0] LAST_STD = STD_INT[3:0];
  localparam [3:0] LAST_X2 = X2_INT[3:0];

  reg [3:0] cnt_q;
  reg [3:0] cnt_d;

  // One period counter feeds every rate so all enables stay aligned
  always @* begin
    if (cnt_q == LAST_STD) begin
      cnt_d = 4'h0;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  // Counter, divider and speed bit latch
  always @(posedge sys_clk) begin
    if (reset) begin
      cnt_q <= 4'h0;
      div2_q <= 1'b0;
      x2_eff_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div2_q <= ~div2_q;
      // Only on the divided clock rising edge, avoids glitching the core clock
      if (!div2_q) begin
        x2_eff_q <= x2_req;
      end
    end
  end

  // Six period tick lands on the twelve period tick, never a short cycle
  assign en12 = (cnt_q == LAST_STD);
  assign en6 = (cnt_q == LAST_STD) || (cnt_q == LAST_X2);

endmodule

// file: hw/cssr_top.v
// Clock speed control register, cycle enables and warm reset handling
// Functional notes
// - Speed bit clear gives 12 periods everywhere; set gives 6 for CPU.
// - Peripheral speed bit clear selects 6 periods, set selects 12.
// - Peripheral speed bits ignored unless the CPU speed bit is set.
// - Reset clears control bits six to zero.
// - Minimum warm reset pulse is a fixed period count in every mode.
// - Warm reset comes from the pin or internal sources.
// - Watchdog reset drives a pulse out on the reset pin.
// - CPU speed bit change applies only on the divided clock rising edge.
// - Standard mode passes the oscillator through a divide by two stage.
`timescale 1ns/1ns
`include "cssr_consts.vh"

module cssr_top #(
  parameter PULSE_PERIODS = `CSSR_PULSE_PERIODS,
  parameter WARM_MIN_PERIODS = `CSSR_WARM_MIN_PERIODS
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  // Reset pin, split into its three parts
  input wire rst_pin_in,
  output reg rst_pin_out_q,
  output reg rst_pin_oe_q,
  // Internal reset sources, one cycle pulses
  input wire watchdog_reset_req,
  input wire counter_array_reset_req,
  input wire timer_reset_req,
  // Cycle enables, index 0 timer0 up to 5 watchdog
  output reg cpu_cycle_en_q,
  output reg standard_speed_mode_q,
  output reg [`CSSR_NUM_PERIPH-1:0] periph_cycle_en_q,
  // Warm reset to the core and peripherals
  output reg core_reset_q
);

  // Counts cut to the counter width on purpose, both stay below 256
  localparam integer PULSE_INT = PULSE_PERIODS;
  localparam integer WARM_LAST_INT = WARM_MIN_PERIODS - 1;
  localparam [7:0] PULSE_LEN = PULSE_INT[7:0];
  localparam [7:0] WARM_LAST = WARM_LAST_INT[7:0];
  // Control register constants, used at the stored width
  localparam [7:0] CTRL_RST = `CSSR_CTRL_RESET;
  localparam [7:0] CTRL_WMASK = `CSSR_CTRL_WMASK;

  // Control register and status flags
  reg [6:0] ctrl_q;
  reg [6:0] ctrl_d;
  reg [3:1] cause_q;
  reg [3:1] cause_d;

  // Reset pin synchroniser and qualification
  reg rst_pin_s1_q;
  reg rst_pin_s2_q;
  reg [7:0] pin_cnt_q;
  reg [7:0] pin_cnt_d;
  reg pin_reset_q;
  reg pin_reset_d;
  reg oe_d1_q;
  reg oe_d2_q;
  wire pin_masked;

  // Internal reset pulse
  reg [7:0] int_cnt_q;
  reg [7:0] int_cnt_d;
  reg drive_q;
  reg drive_d;
  wire any_int_req;
  wire warm_active;

  // Register access decode
  wire ctrl_sel;
  wire stat_sel;
  wire ctrl_wr;
  wire stat_wr;
  wire ctrl_rd;
  wire stat_rd;
  wire [7:0] stat_word;
  reg [7:0] rdata_d;

  // Rate generator outputs, derived enables and reset helper nets
  wire div2;
  wire x2_eff;
  wire en6;
  wire en12;
  wire [`CSSR_NUM_PERIPH-1:0] periph_en;
  wire cpu_en;
  wire [`CSSR_NUM_PERIPH-1:0] periph_fast;
  wire pin_rise;
  wire other_int_req;
  wire int_busy;

  assign ctrl_sel = (reg_addr == `CSSR_CTRL_OFF);
  assign stat_sel = (reg_addr == `CSSR_STAT_OFF);

  // Strobes qualified by the decoded address
  assign ctrl_wr = reg_wr && ctrl_sel;
  assign stat_wr = reg_wr && stat_sel;
  assign ctrl_rd = reg_rd && ctrl_sel;
  assign stat_rd = reg_rd && stat_sel;

  // Divider and validated speed bit
  cssr_rate_gen u_rate_gen (
    .sys_clk(sys_clk),
    .reset(reset),
    .x2_req(ctrl_q[`CSSR_BIT_CPU]),
    .div2_q(div2),
    .x2_eff_q(x2_eff),
    .en6(en6),
    .en12(en12)
  );

  // CPU cycle rate follows the validated speed bit
  assign cpu_en = x2_eff ? en6 : en12;

  // Per-peripheral rate selection, gated by the CPU speed bit
  genvar gi;
  generate
    for (gi = 0; gi < `CSSR_NUM_PERIPH; gi = gi + 1) begin : g_periph
      // Clear bit means fast only while the CPU itself runs fast
      assign periph_fast[gi] = x2_eff && !ctrl_q[gi + 1];
      assign periph_en[gi] = periph_fast[gi] ? en6 : en12;
    end
  endgenerate

  // Two flops before the pin level is looked at
  always @(posedge sys_clk) begin
    if (reset) begin
      rst_pin_s1_q <= 1'b0;
      rst_pin_s2_q <= 1'b0;
    end else begin
      rst_pin_s1_q <= rst_pin_in;
      rst_pin_s2_q <= rst_pin_s1_q;
    end
  end

  // Our own drive echoes back through the synchroniser, so mask it
  assign pin_masked = rst_pin_oe_q | oe_d1_q | oe_d2_q;

  // Pin pulse qualification counts oscillator periods, mode independent
  always @* begin
    pin_cnt_d = pin_cnt_q;
    pin_reset_d = pin_reset_q;
    if (!rst_pin_s2_q || pin_masked) begin
      pin_cnt_d = 8'h00;
      pin_reset_d = 1'b0;
    end else if (pin_cnt_q == WARM_LAST) begin
      pin_reset_d = 1'b1;
    end else begin
      pin_cnt_d = pin_cnt_q + 8'h01;
    end
  end

  // Sources other than the watchdog leave the pin alone
  assign other_int_req = counter_array_reset_req | timer_reset_req;
  assign any_int_req = watchdog_reset_req | other_int_req;

  // Internal sources start a fixed length reset, watchdog also drives the pin
  always @* begin
    int_cnt_d = int_cnt_q;
    drive_d = drive_q;
    if (any_int_req) begin
      int_cnt_d = PULSE_LEN;
      drive_d = drive_q | watchdog_reset_req;
    end else if (int_busy) begin
      int_cnt_d = int_cnt_q - 8'h01;
      if (int_cnt_q == 8'h01) begin
        drive_d = 1'b0;
      end
    end else begin
      drive_d = 1'b0;
    end
  end

  // Internal pulse still counting down
  assign int_busy = (int_cnt_q != 8'h00);

  // Qualified pin level just rising, sets the pin cause flag
  assign pin_rise = pin_reset_d && !pin_reset_q;

  // Either path holds the core in warm reset
  assign warm_active = pin_reset_q | int_busy;

  // Reset qualification state
  always @(posedge sys_clk) begin
    if (reset) begin
      pin_cnt_q <= 8'h00;
      pin_reset_q <= 1'b0;
      int_cnt_q <= 8'h00;
      drive_q <= 1'b0;
      oe_d1_q <= 1'b0;
      oe_d2_q <= 1'b0;
    end else begin
      pin_cnt_q <= pin_cnt_d;
      pin_reset_q <= pin_reset_d;
      int_cnt_q <= int_cnt_d;
      drive_q <= drive_d;
      oe_d1_q <= rst_pin_oe_q;
      oe_d2_q <= oe_d1_q;
    end
  end

  // Control register next value
  always @* begin
    ctrl_d = ctrl_q;
    if (warm_active) begin
      ctrl_d = CTRL_RST[6:0];
    end else if (ctrl_wr) begin
      // Reserved top bit is never stored and always reads zero
      ctrl_d = reg_wdata[6:0] & CTRL_WMASK[6:0];
    end
  end

  // Cause flags: write one to clear, a new event wins over the clear
  always @* begin
    cause_d = cause_q;
    if (stat_wr) begin
      cause_d = cause_q & ~reg_wdata[3:1];
    end
    if (pin_rise) begin
      cause_d[`CSSR_STAT_PIN] = 1'b1;
    end
    if (watchdog_reset_req) begin
      cause_d[`CSSR_STAT_WDOG] = 1'b1;
    end
    if (other_int_req) begin
      cause_d[`CSSR_STAT_INT] = 1'b1;
    end
  end

  // Control and status storage
  always @(posedge sys_clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RST[6:0];
      cause_q <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
      cause_q <= cause_d;
    end
  end

  // Status word, unused bits read zero
  assign stat_word = {3'h0, warm_active, cause_q, x2_eff};

  // Read mux, unmapped addresses and idle cycles give zero
  always @* begin
    rdata_d = 8'h00;
    if (ctrl_rd) begin
      rdata_d = {1'b0, ctrl_q};
    end else if (stat_rd) begin
      rdata_d = stat_word;
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  // Registered cycle enables and mode flag
  always @(posedge sys_clk) begin
    if (reset) begin
      cpu_cycle_en_q <= 1'b0;
      standard_speed_mode_q <= 1'b1;
      periph_cycle_en_q <= {`CSSR_NUM_PERIPH{1'b0}};
    end else begin
      cpu_cycle_en_q <= cpu_en;
      // Divider in the path whenever the validated bit is clear
      standard_speed_mode_q <= ~x2_eff;
      periph_cycle_en_q <= periph_en;
    end
  end

  // Warm reset to the core, one register after either source
  always @(posedge sys_clk) begin
    if (reset) begin
      core_reset_q <= 1'b0;
    end else begin
      core_reset_q <= warm_active;
    end
  end

  // Pin drive, level and enable move together so the pin never floats mid-pulse
  always @(posedge sys_clk) begin
    if (reset) begin
      rst_pin_out_q <= 1'b0;
      rst_pin_oe_q <= 1'b0;
    end else begin
      rst_pin_out_q <= drive_d;
      rst_pin_oe_q <= drive_d;
    end
  end

endmodule

// file: verification/cssr_top_assertions.sv
// Port checks for the clock speed and warm reset block
`timescale 1ns/1ns
module cssr_chk #(
  parameter WARM_MIN_PERIODS = 24
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Reset pin and sources
  input wire rst_pin_in,
  input wire rst_pin_out_q,
  input wire rst_pin_oe_q,
  input wire watchdog_reset_req,
  input wire counter_array_reset_req,
  input wire timer_reset_req,
  // Enables and warm reset
  input wire cpu_cycle_en_q,
  input wire standard_speed_mode_q,
  input wire [5:0] periph_cycle_en_q,
  input wire core_reset_q
);
  wire int_req = watchdog_reset_req | counter_array_reset_req | timer_reset_req;
  reg [7:0] pin_cnt_q = 8'h00;
  // High run length of the pin, saturating so long holds stay counted
  always @(posedge sys_clk) begin
    if (!rst_pin_in) pin_cnt_q <= 8'h00;
    else if (pin_cnt_q != 8'hFF) pin_cnt_q <= pin_cnt_q + 8'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_min_six: assert property (cpu_cycle_en_q |=> !cpu_cycle_en_q [*5])
    else $error("cpu pulses too close");
  a_std_twelve: assert property (cpu_cycle_en_q && standard_speed_mode_q
    |-> ##6 !(cpu_cycle_en_q && standard_speed_mode_q))
    else $error("standard rate pulse at six");
  a_dbl_six: assert property (cpu_cycle_en_q && !standard_speed_mode_q ##1 !standard_speed_mode_q [*6]
    |-> cpu_cycle_en_q)
    else $error("double rate pulse missing");
  a_std_periph: assert property (standard_speed_mode_q && $past(standard_speed_mode_q)
    |-> periph_cycle_en_q == {6{cpu_cycle_en_q}})
    else $error("peripheral rate off in standard mode");
  a_wdog_pin: assert property (watchdog_reset_req |=> rst_pin_oe_q && rst_pin_out_q)
    else $error("pin not driven after watchdog");
  a_int_reset: assert property (int_req |-> ##[1:2] core_reset_q)
    else $error("internal request lost");
  // Pin run length as it stood three edges back, before sync and qualify delay
  a_short_pin: assert property ($rose(core_reset_q) && !$past(int_req) && !$past(int_req, 2)
    |-> $past(pin_cnt_q, 3) >= WARM_MIN_PERIODS)
    else $error("short pin pulse taken");
  a_long_pin: assert property (pin_cnt_q == WARM_MIN_PERIODS + 6 |-> core_reset_q)
    else $error("long pin pulse ignored");
endmodule

bind cssr_top cssr_chk #(.WARM_MIN_PERIODS(WARM_MIN_PERIODS)) chk_u (.sys_clk, .reset, .rst_pin_in, .rst_pin_out_q,
  .rst_pin_oe_q, .watchdog_reset_req, .counter_array_reset_req, .timer_reset_req, .cpu_cycle_en_q,
  .standard_speed_mode_q, .periph_cycle_en_q, .core_reset_q);

// file: verification/cssr_rst_source.sv
// External supervisor model driving the warm reset pin
`timescale 1ns/1ns
module cssr_rst_source (
  // Clock and command
  input wire sys_clk,
  input wire go,
  input wire [7:0] hold_len,
  // Device side of the pin
  input wire dev_oe,
  input wire dev_out,
  // Resolved pin level
  output wire pin_level
);
  reg [7:0] left_q = 8'h00;
  // Active high hold for the commanded count, then release
  always @(posedge sys_clk) begin
    if (go) left_q <= hold_len;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end
  // Pull-down wins once nobody drives high
  assign pin_level = (left_q != 8'h00) | (dev_oe & dev_out);
endmodule

// file: verification/cssr_top_tb_top.sv
// Self-checking bench for the clock speed and warm reset block
`timescale 1ns/1ns
module cssr_top_tb_top;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [2:0] req = 3'h0;
  reg go = 1'b0;
  reg [7:0] hold_len = 8'h00;
  reg [39:0] mtab = 40'h2B7F017E00;
  reg [7:0] v;
  wire [7:0] reg_rdata_q;
  wire [5:0] periph_cycle_en_q;
  wire rst_pin_in, rst_pin_out_q, rst_pin_oe_q, cpu_cycle_en_q, standard_speed_mode_q, core_reset_q;
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;
  integer cpu_n, crst_n, oe_n, i, k, m;
  integer per_n [0:5];
  cssr_top dut_u (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .rst_pin_in,
    .rst_pin_out_q, .rst_pin_oe_q, .watchdog_reset_req(req[0]), .counter_array_reset_req(req[1]),
    .timer_reset_req(req[2]), .cpu_cycle_en_q, .standard_speed_mode_q, .periph_cycle_en_q, .core_reset_q);
  cssr_rst_source ext_u (.sys_clk, .go, .hold_len, .dev_oe(rst_pin_oe_q), .dev_out(rst_pin_out_q),
    .pin_level(rst_pin_in));
  always #25 sys_clk = ~sys_clk;
  // Tally at the falling edge, clear of edge races
  always @(negedge sys_clk) begin
    cpu_n = cpu_n + cpu_cycle_en_q;
    crst_n = crst_n + core_reset_q;
    oe_n = oe_n + (rst_pin_oe_q & rst_pin_out_q);
    for (k = 0; k < 6; k = k + 1) per_n[k] = per_n[k] + periph_cycle_en_q[k];
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Data stands only in the cycle after the strobe
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
    end
  endtask
  task clr;
    begin
      cpu_n = 0;
      crst_n = 0;
      oe_n = 0;
      for (k = 0; k < 6; k = k + 1) per_n[k] = 0;
    end
  endtask
  task pin_pulse(input [7:0] n);
    begin
      @(posedge sys_clk);
      go <= 1'b1;
      hold_len <= n;
      @(posedge sys_clk);
      go <= 1'b0;
      clr;
      repeat (60) @(posedge sys_clk);
    end
  endtask
  task conclude;
    begin
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Hang guard, well above the whole sequence
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    wr(8'h8E, 8'h55);
    rd(8'h10, v);
    chk(v, 8'h00);
    rd(8'h8F, v);
    chk(v, 8'h00);
    // Rate table: standard, ignored peripheral bits, double, mixed
    for (i = 0; i < 5; i = i + 1) begin
      v = mtab[i*8 +: 8];
      wr(8'h8F, v);
      repeat (14) @(posedge sys_clk);
      clr;
      repeat (48) @(posedge sys_clk);
      chk(cpu_n, v[0] ? 8 : 4);
      chk(standard_speed_mode_q, {7'h00, ~v[0]});
      for (k = 0; k < 6; k = k + 1) chk(per_n[k], (v[0] && !v[k+1]) ? 8 : 4);
    end
    // Pin pulses in both modes; the count is mode independent
    for (m = 0; m < 2; m = m + 1) begin
      wr(8'h8F, m);
      pin_pulse(8'd20);
      chk(crst_n, 0);
      pin_pulse(8'd24);
      chk(crst_n != 0, 1);
      // Long hold keeps the core in reset for the hold less the qualifying 23
      pin_pulse(8'd40);
      chk(crst_n, 17);
      rd(8'h8F, v);
      chk(v, 8'h00);
    end
    // Each internal source; only the watchdog drives the pin
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'h8F, 8'h01);
      @(posedge sys_clk);
      req <= 3'h1 << i;
      @(posedge sys_clk);
      req <= 3'h0;
      clr;
      repeat (40) @(posedge sys_clk);
      chk(crst_n, 24);
      chk(oe_n, i == 0 ? 24 : 0);
    end
    // Cause flags: pin, watchdog and other source all seen, then cleared
    rd(8'hFE, v);
    chk(v, 8'h0E);
    wr(8'hFE, 8'h0E);
    rd(8'hFE, v);
    chk(v, 8'h00);
    conclude;
  end
endmodule
